// file: test/host_timers_counters_assertions.sv
// Port-level checker for the host timers and counters block
module host_timers_counters_assertions
  import host_timers_pkg::*;
(
  input wire logic         i_core_clk,
  input wire logic         i_rst_n,
  input wire host_req_type i_host_req,
  input wire logic         i_bus_16bit,
  input wire host_rsp_type o_host_rsp,
  input wire logic [31:0]  i_tx_fifo_word,
  input wire logic         i_tx_fifo_valid,
  input wire logic         o_tx_fifo_ready,
  input wire logic [15:0]  o_tx_net_half,
  input wire logic         o_tx_net_valid,
  input wire logic         o_rx_fifo_valid,
  input wire logic         o_timer_event,
  input wire logic         o_dropped_half_event
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  AST_ACK: assert property ((i_host_req.rd || i_host_req.wr) |=> o_host_rsp.ack)
    else $error("no ack after request");
  AST_NO_ACK: assert property (!(i_host_req.rd || i_host_req.wr) |=> !o_host_rsp.ack)
    else $error("ack without request");
  AST_TX_ORDER: assert property ((i_tx_fifo_valid && o_tx_fifo_ready) |=>
    (o_tx_net_valid && o_tx_net_half == $past(i_tx_fifo_word[15:0]))
    ##1 (o_tx_net_half == $past(i_tx_fifo_word[31:16], 2)))
    else $error("tx half order wrong");
  AST_TIMER_PULSE: assert property (o_timer_event |=> !o_timer_event)
    else $error("timer event too long");
  AST_DROP_PULSE: assert property (o_dropped_half_event |=> !o_dropped_half_event)
    else $error("drop event too long");
  AST_RX_PULSE: assert property (o_rx_fifo_valid |=> !o_rx_fifo_valid)
    else $error("rx valid too long");
  AST_CNT_HIGH: assert property ((i_host_req.rd && !i_bus_16bit
    && i_host_req.addr == timer_count_offset) |=> o_host_rsp.rdata[31:16] == 16'h0000)
    else $error("count high bits set");
  AST_UNMAPPED: assert property ((i_host_req.rd && i_host_req.addr == 8'h94)
    |=> o_host_rsp.rdata == 32'h00000000)
    else $error("unmapped read not zero");
endmodule

// file: test/net_loopback.sv
// Network side model: sends every transmitted half-word straight back
module net_loopback (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic [15:0] i_half,
  input  wire logic        i_valid,
  output logic [15:0]      o_half,
  output logic             o_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle line inverts its own previous value every cycle, so it alternates between the last value and its inverse
  always_ff @(posedge i_core_clk) begin
    o_valid <= i_rst_n && i_valid;
    o_half  <= i_valid ? i_half : ~o_half;
  end
endmodule

// file: test/tb_host_timers_counters.sv
// Self-checking bench for the host timers and counters block
module tb_host_timers_counters;
  timeunit 1ns;
  timeprecision 1ps;
  import host_timers_pkg::*;
  logic i_core_clk = 0, i_rst_n = 0, i_bus_16bit = 0, drop = 0, txv = 0;
  logic rxv, txr, tnv, rfv, tev, dev;
  logic [15:0] rxh, tnh;
  logic [31:0] txw = 32'hbeef1234, rfw, q, r;
  host_req_type req = '0;
  host_rsp_type rsp;
  int num_errors = 0, comparisons = 0, cycles = 0, n;
  always #20 i_core_clk = ~i_core_clk;
  host_timers_counters dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_host_req(req),
    .i_bus_16bit(i_bus_16bit), .o_host_rsp(rsp), .i_rx_frame_dropped(drop),
    .i_tx_fifo_word(txw), .i_tx_fifo_valid(txv), .o_tx_fifo_ready(txr),
    .o_tx_net_half(tnh), .o_tx_net_valid(tnv), .i_rx_net_half(rxh), .i_rx_net_valid(rxv),
    .o_rx_fifo_word(rfw), .o_rx_fifo_valid(rfv), .o_timer_event(tev),
    .o_dropped_half_event(dev));
  net_loopback peer (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_half(tnh),
    .i_valid(tnv), .o_half(rxh), .o_valid(rxv));
  task automatic tally_and_finish();
    if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  // Requests are taken three cycles apart; the free counter checks rely on that
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    req <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge i_core_clk);
    req.rd <= 1'b0;
    req.wr <= 1'b0;
    // Ack stands only in the cycle after the strobe, so look there
    #1 chk(rsp.ack === 1'b1, "no ack");
    q = rsp.rdata;
    @(posedge i_core_clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
    acc(0, a, 32'h0);
    chk(q === e, m);
  endtask
  task automatic t_reset();
    rd_chk(timer_config_offset, 32'h0000ffff, "config reset");
    rd_chk(timer_count_offset, 32'h0000ffff, "count reset");
    rd_chk(host_word_order_offset, 32'h0, "order reset");
    rd_chk(rx_dropped_frames_offset, 32'h0, "drop reset");
    rd_chk(8'h94, 32'h0, "unmapped");
  endtask
  task automatic wait_ev();
    n = 0;
    do begin
      @(posedge i_core_clk);
      #1 n++;
    end while (tev !== 1'b1 && n < 400);
  endtask
  task automatic t_timer();
    acc(1, timer_config_offset, 32'h20000003);
    rd_chk(timer_config_offset, 32'h20000003, "run readback");
    wait_ev();
    wait_ev();
    chk(n === 4 * timer_tick_cycles, "event period");
    acc(1, timer_config_offset, 32'h00000003);
    rd_chk(timer_config_offset, 32'h0000ffff, "preload forced");
    acc(0, timer_count_offset, 32'h0);
    r = q;
    repeat (30) @(posedge i_core_clk);
    rd_chk(timer_count_offset, r, "halted count moved");
  endtask
  task automatic t_free();
    acc(0, free_running_count_offset, 32'h0);
    r = q;
    rd_chk(free_running_count_offset, r + 32'd3, "free count step");
    i_bus_16bit <= 1'b1;
    // High half first, so a missing latch would show a later low half
    acc(0, free_running_count_offset + 8'h02, 32'h0);
    r[31:16] = q[15:0];
    acc(0, free_running_count_offset, 32'h0);
    r[15:0] = q[15:0];
    i_bus_16bit <= 1'b0;
    rd_chk(free_running_count_offset, r + 32'd6, "latched count");
  endtask
  task automatic t_order();
    i_bus_16bit <= 1'b1;
    acc(1, timer_config_offset, 32'h00001234);
    rd_chk(timer_config_offset, 32'h00001234, "low half");
    rd_chk(timer_config_offset + 8'h02, 32'h0, "high half");
    acc(1, host_word_order_offset, 32'h0000ffff);
    acc(1, host_word_order_offset + 8'h02, 32'h0000ffff);
    rd_chk(timer_config_offset + 8'h02, 32'h00001234, "swapped low");
    rd_chk(timer_config_offset, 32'h0, "swapped high");
    i_bus_16bit <= 1'b0;
    rd_chk(timer_config_offset, 32'h00001234, "wide read");
    acc(1, host_word_order_offset, 32'h0);
  endtask
  task automatic t_drop();
    repeat (3) begin
      @(posedge i_core_clk) drop <= 1'b1;
      @(posedge i_core_clk) drop <= 1'b0;
    end
    rd_chk(rx_dropped_frames_offset, 32'h3, "drop count");
    rd_chk(rx_dropped_frames_offset, 32'h0, "clear on read");
  endtask
  task automatic t_fifo();
    @(posedge i_core_clk) txv <= 1'b1;
    @(posedge i_core_clk) txv <= 1'b0;
    n = 0;
    do begin
      @(posedge i_core_clk);
      #1 n++;
    end while (rfv !== 1'b1 && n < 10);
    chk(rfw === txw, "loopback word");
  endtask
  initial begin
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_timer();
    t_free();
    t_order();
    t_drop();
    t_fifo();
    tally_and_finish();
  end
endmodule
bind host_timers_counters host_timers_counters_assertions chk_i (.i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n), .i_host_req(i_host_req), .i_bus_16bit(i_bus_16bit),
  .o_host_rsp(o_host_rsp), .i_tx_fifo_word(i_tx_fifo_word),
  .i_tx_fifo_valid(i_tx_fifo_valid), .o_tx_fifo_ready(o_tx_fifo_ready),
  .o_tx_net_half(o_tx_net_half), .o_tx_net_valid(o_tx_net_valid),
  .o_rx_fifo_valid(o_rx_fifo_valid), .o_timer_event(o_timer_event),
  .o_dropped_half_event(o_dropped_half_event));

// file: verilog/host_timers_counters.sv
// Host timer, free-running counter, dropped-frame counter and word order control
//
// Contract
// - Run bit 29 starts and halts timer
// - Run falling edge forces preload to FFFFh
// - Preload is bits 15-0, host writable
// - Count register shows live timer, resets FFFFh
// - Timer raises host interrupt events periodically
// - Word order matters only in 16-bit mode
// - Normal order: A1 high selects high half
// - All ones order: A1 high selects low half
// - FIFO data moves low half-word first
// - Free counter 32-bit, zero at reset, per cycle
// - Free counter wraps to zero at maximum
// - 16-bit read latches full count on first half
// - Free counter may take 160ns to clear
// - Free counter runs in every power state
// - Dropped counter increments per dropped frame
// - Reading dropped counter returns it and clears
// - Interrupt when dropped count crosses midpoint
module host_timers_counters
  import host_timers_pkg::*;
(
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_rst_n,
  // Host bus
  input  wire host_req_type i_host_req,
  input  wire logic         i_bus_16bit,
  output host_rsp_type      o_host_rsp,
  // Receive path events
  input  wire logic         i_rx_frame_dropped,
  // FIFO data path, full 32-bit words on the internal side
  input  wire logic [31:0]  i_tx_fifo_word,
  input  wire logic         i_tx_fifo_valid,
  output logic              o_tx_fifo_ready,
  output logic [15:0]       o_tx_net_half,
  output logic              o_tx_net_valid,
  input  wire logic [15:0]  i_rx_net_half,
  input  wire logic         i_rx_net_valid,
  output logic [31:0]       o_rx_fifo_word,
  output logic              o_rx_fifo_valid,
  // Events
  output logic              o_timer_event,
  output logic              o_dropped_half_event
);

  logic [15:0] timer_preload_value;
  logic        timer_run;
  logic        timer_run_q;
  logic [15:0] timer_current_value;
  logic        tick;
  logic [31:0] host_word_order;
  logic [31:0] free_running_tick_value;
  logic [31:0] free_latch;
  logic        free_latch_valid;
  logic [31:0] dropped_frame_tally;
  logic [31:0] next_dropped;
  logic        tx_half_sel;
  logic [31:0] tx_word;
  logic        rx_half_sel;
  logic [15:0] rx_low_half;

  wire logic       rd    = i_host_req.rd;
  wire logic       wr    = i_host_req.wr;
  wire logic [7:0] addr  = {i_host_req.addr[7:2], 2'b00};
  wire logic       a1    = i_host_req.addr[1];
  wire logic       high  = sel_high_half(a1, host_word_order);

  // Half-word writes update only the selected half
  function automatic logic [31:0] merge_write(input logic [31:0] old, input logic [31:0] wd,
                                              input logic is16, input logic hi);
    if (!is16)
      return wd;
    return hi ? {wd[15:0], old[15:0]} : {old[31:16], wd[15:0]};
  endfunction

  timer_tick_divider u_tick (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_run      (timer_run),
    .o_tick     (tick)
  );

  // Timer configuration
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      timer_preload_value <= timer_preload_reset;
      timer_run           <= 1'b0;
    end else if (wr && addr == timer_config_offset) begin
      logic [31:0] merged;
      merged = merge_write({2'b00, timer_run, 13'h0000, timer_preload_value},
                           i_host_req.wdata, i_bus_16bit, high);
      timer_run <= merged[timer_run_bit];
      if (timer_run && !merged[timer_run_bit])
        timer_preload_value <= timer_preload_reset;
      else
        timer_preload_value <= merged[15:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n)
      timer_run_q <= 1'b0;
    else
      timer_run_q <= timer_run;
  end

  // Live count; loads preload on each start, reloads after passing zero
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      timer_current_value <= timer_count_reset;
      o_timer_event       <= 1'b0;
    end else begin
      o_timer_event <= 1'b0;
      if (timer_run && !timer_run_q) begin
        timer_current_value <= timer_preload_value;
      end else if (timer_run && tick) begin
        if (timer_current_value == 16'h0000) begin
          timer_current_value <= timer_preload_value;
          o_timer_event       <= 1'b1;
        end else begin
          timer_current_value <= timer_current_value - 16'h0001;
        end
      end
    end
  end

  // Word order register
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n)
      host_word_order <= word_order_reset;
    else if (wr && addr == host_word_order_offset)
      host_word_order <= merge_write(host_word_order, i_host_req.wdata, i_bus_16bit, high);
  end

  // No power-state gating exists here, so the counter never stops
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n)
      free_running_tick_value <= free_running_reset;
    else
      free_running_tick_value <= free_running_tick_value + 32'h00000001;
  end

  // First half read latches the whole count; the second half reads the latch
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      free_latch       <= free_running_reset;
      free_latch_valid <= 1'b0;
    end else if (rd && i_bus_16bit && addr == free_running_count_offset) begin
      if (!free_latch_valid) begin
        free_latch       <= free_running_tick_value;
        free_latch_valid <= 1'b1;
      end else begin
        free_latch_valid <= 1'b0;
      end
    end
  end

  // Increment applies after the clear: a drop in the clearing read cycle counts as one
  always_comb begin
    next_dropped = dropped_frame_tally;
    if (rd && addr == rx_dropped_frames_offset)
      next_dropped = dropped_reset;
    if (i_rx_frame_dropped)
      next_dropped = next_dropped + 32'h00000001;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      dropped_frame_tally  <= dropped_reset;
      o_dropped_half_event <= 1'b0;
    end else begin
      dropped_frame_tally  <= next_dropped;
      // Judged on the next value, so a clearing read in the same cycle hides the crossing
      o_dropped_half_event <= i_rx_frame_dropped
                              && next_dropped == dropped_midpoint + 32'h00000001;
    end
  end

  // Read data; in 16-bit mode the selected half appears on the low lanes.
  // In 16-bit mode the dropped counter clears on each half read, so software
  // reading it that way must accept that the second half reads zero.
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_host_rsp <= '0;
    end else begin
      logic [31:0] word;
      word = 32'h00000000;
      unique case (addr)
        timer_config_offset:       word = {2'b00, timer_run, 13'h0000, timer_preload_value};
        timer_count_offset:        word = {16'h0000, timer_current_value};
        host_word_order_offset:    word = host_word_order;
        free_running_count_offset: word = (i_bus_16bit && free_latch_valid)
                                          ? free_latch : free_running_tick_value;
        rx_dropped_frames_offset:  word = dropped_frame_tally;
        default:                   word = 32'h00000000;
      endcase
      o_host_rsp.ack <= rd || wr;
      if (rd && !i_bus_16bit)
        o_host_rsp.rdata <= word;
      else if (rd)
        o_host_rsp.rdata <= {16'h0000, high ? word[31:16] : word[15:0]};
    end
  end

  // Transmit to network: low half-word first, whatever the host order
  assign o_tx_fifo_ready = !o_tx_net_valid || tx_half_sel;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      tx_word        <= 32'h00000000;
      tx_half_sel    <= 1'b0;
      o_tx_net_half  <= 16'h0000;
      o_tx_net_valid <= 1'b0;
    end else if (i_tx_fifo_valid && o_tx_fifo_ready) begin
      tx_word        <= i_tx_fifo_word;
      o_tx_net_half  <= i_tx_fifo_word[15:0];
      o_tx_net_valid <= 1'b1;
      tx_half_sel    <= 1'b0;
    end else if (o_tx_net_valid && !tx_half_sel) begin
      o_tx_net_half <= tx_word[31:16];
      tx_half_sel   <= 1'b1;
    end else begin
      o_tx_net_valid <= 1'b0;
      tx_half_sel    <= 1'b0;
    end
  end

  // Receive from network: first half is the low half-word
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rx_half_sel     <= 1'b0;
      rx_low_half     <= 16'h0000;
      o_rx_fifo_word  <= 32'h00000000;
      o_rx_fifo_valid <= 1'b0;
    end else begin
      o_rx_fifo_valid <= 1'b0;
      if (i_rx_net_valid) begin
        if (!rx_half_sel) begin
          rx_low_half <= i_rx_net_half;
          rx_half_sel <= 1'b1;
        end else begin
          o_rx_fifo_word  <= {i_rx_net_half, rx_low_half};
          o_rx_fifo_valid <= 1'b1;
          rx_half_sel     <= 1'b0;
        end
      end
    end
  end

endmodule

// file: verilog/host_timers_pkg.sv
// Constants and carrier types for the host timers and counters block
package host_timers_pkg;

  // Register offsets (byte addresses on the host bus)
  localparam logic [7:0] timer_config_offset       = 8'h8c;
  localparam logic [7:0] timer_count_offset        = 8'h90;
  localparam logic [7:0] host_word_order_offset    = 8'h98;
  localparam logic [7:0] free_running_count_offset = 8'h9c;
  localparam logic [7:0] rx_dropped_frames_offset  = 8'ha0;

  // Field positions and reset values
  localparam int          timer_run_bit            = 29;
  localparam logic [15:0] timer_preload_reset      = 16'hffff;
  localparam logic [15:0] timer_count_reset        = 16'hffff;
  localparam logic [31:0] word_order_reset         = 32'h00000000;
  localparam logic [31:0] word_order_swapped       = 32'hffffffff;
  localparam logic [31:0] free_running_reset       = 32'h00000000;
  localparam logic [31:0] dropped_reset            = 32'h00000000;
  localparam logic [31:0] dropped_midpoint         = 32'h7fffffff;

  // Timing
  localparam int clock_period_ns      = 40;
  localparam int counter_clear_ns     = 160;
  localparam int counter_clear_cycles = counter_clear_ns / clock_period_ns;
  // Timer decrements once per this many core clocks (1 us tick at 25 MHz)
  localparam int timer_tick_ns        = 1000;
  localparam int timer_tick_cycles    = timer_tick_ns / clock_period_ns;

  // Host bus request, as seen at the block
  typedef struct packed {
    logic        rd;        // One-cycle read strobe
    logic        wr;        // One-cycle write strobe
    logic [7:0]  addr;      // Byte address, bit 1 selects half-word in 16-bit mode
    logic [31:0] wdata;
  } host_req_type;

  // Host bus answer
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } host_rsp_type;

  // Returns 1 when a 16-bit access lands on the high half-word of a register
  function automatic logic sel_high_half(input logic a1, input logic [31:0] order);
    return (order == word_order_swapped) ? ~a1 : a1;
  endfunction

endpackage

// file: verilog/timer_tick_divider.sv
// Divider that makes the general purpose timer tick enable
module timer_tick_divider
  import host_timers_pkg::*;
(
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  // Control
  input  wire logic i_run,
  // Tick
  output logic      o_tick
);

  logic [7:0] div_count;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || !i_run) begin
      div_count <= 8'h00;
      o_tick    <= 1'b0;
    end else if (div_count == 8'(timer_tick_cycles - 1)) begin
      div_count <= 8'h00;
      o_tick    <= 1'b1;
    end else begin
      div_count <= div_count + 8'h01;
      o_tick    <= 1'b0;
    end
  end

endmodule
